// >>> spar_checker.sv
`include "spar_consts.vh"
// ====================
// Link protocol checks
module spar_checker #(
    parameter [2:0] HREPLY_WDATA = `SPAR_HREPLY_WDATA
) (
    input wire        clk,
    input wire        nrst,
    input wire        req_valid,
    input wire        req_ready,
    input wire [28:0] req_addr_first,
    input wire [28:0] req_addr_second,
    input wire [28:0] system_address_bus,
    input wire        address_valid_strobe,
    input wire [2:0]  host_reply,
    input wire        shared_data_bus_oe_n,
    input wire        slave_clock_true,
    input wire        slave_clock_comp,
    input wire        slave_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [28:0] first_reg;
    reg [28:0] second_reg;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_reg <= 29'h00000000;
            second_reg <= 29'h00000000;
        end else if (req_valid && req_ready) begin
            first_reg <= req_addr_first;
            second_reg <= req_addr_second;
        end
    end
    a_first_word: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && req_ready |-> ##[1:2] address_valid_strobe && system_address_bus == first_reg)
        else $error("first address word missing");
    a_second_word: assert property (@(posedge clk) disable iff (!nrst)
        $fell(address_valid_strobe) |-> (system_address_bus == second_reg) [*3])
        else $error("second address word wrong");
    a_strobe_len: assert property (@(posedge clk) disable iff (!nrst)
        $rose(address_valid_strobe) |-> address_valid_strobe [*3] ##1 !address_valid_strobe)
        else $error("strobe not one link cycle");
    a_wdata_drive: assert property (@(posedge clk) disable iff (!nrst)
        host_reply == HREPLY_WDATA |-> !shared_data_bus_oe_n)
        else $error("write code without data drive");
    a_clk_third: assert property (@(posedge clk) disable iff (!nrst)
        $rose(slave_clock_true) |=> !slave_clock_true ##1 !slave_clock_true ##1 slave_clock_true)
        else $error("slave clock not one third");
    a_clk_pair: assert property (@(posedge clk) disable iff (!nrst)
        slave_clock_comp == !slave_clock_true)
        else $error("slave clock pair not complementary");
    a_reset_hold: assert property (@(posedge clk) !nrst |-> !slave_reset_n)
        else $error("slave reset not asserted");
    a_reset_mono: assert property (@(posedge clk) disable iff (!nrst)
        slave_reset_n |=> slave_reset_n)
        else $error("slave reset release not monotonic");
endmodule
bind spar_host_port spar_checker #(.HREPLY_WDATA(HREPLY_WDATA)) spar_checker_i (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr_first(req_addr_first), .req_addr_second(req_addr_second),
    .system_address_bus(system_address_bus), .address_valid_strobe(address_valid_strobe),
    .host_reply(host_reply), .shared_data_bus_oe_n(shared_data_bus_oe_n),
    .slave_clock_true(slave_clock_true), .slave_clock_comp(slave_clock_comp), .slave_reset_n(slave_reset_n)
);

// >>> spar_clk_div.v
`include "spar_consts.vh"

// ============================================================
// Divide-by-N slave clock with one-cycle update tick
module spar_clk_div #(
    parameter DIV   = `SPAR_CLK_DIV,
    parameter PHASE = `SPAR_TICK_PHASE
) (
    input  wire clk,
    input  wire nrst,
    output wire tick,
    output wire clk_true,
    output wire clk_comp
);

    reg  [3:0] cnt_reg;
    reg  [3:0] cnt_next;
    reg        true_reg;
    reg        comp_reg;

    always @* begin
        if (cnt_reg == DIV[3:0] - 4'h1)
            cnt_next = 4'h0;
        else
            cnt_next = cnt_reg + 4'h1;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg  <= 4'h0;
            true_reg <= 1'b0;
            comp_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_next;
            true_reg <= (cnt_next == 4'h0);
            comp_reg <= (cnt_next != 4'h0);
        end
    end

    // Tick falls while the slave clock is low
    assign tick     = (cnt_reg == PHASE[3:0]);
    assign clk_true = true_reg;
    assign clk_comp = comp_reg;

endmodule

// >>> spar_consts.vh
`ifndef SPAR_CONSTS_VH
`define SPAR_CONSTS_VH

// ============================================================
// Link widths
`define SPAR_ADDR_W        29
`define SPAR_DATA_W        64
`define SPAR_HREPLY_W      3
`define SPAR_SREPLY_W      2

// ============================================================
// Default reply encodings, agreed with the slave
`define SPAR_HREPLY_IDLE   3'h0
`define SPAR_HREPLY_WDATA  3'h1
`define SPAR_HREPLY_RDATA  3'h2
`define SPAR_SREPLY_IDLE   2'h0
`define SPAR_SREPLY_WDONE  2'h1
`define SPAR_SREPLY_RDRDY  2'h2

// ============================================================
// Slave clock divide ratio and divider tick phase
`define SPAR_CLK_DIV       3
`define SPAR_TICK_PHASE    1

// ============================================================
// Reset values
`define SPAR_ADDR_RST      29'h00000000
`define SPAR_DATA_RST      64'h0000000000000000

`endif

// >>> spar_host_port.v
`include "spar_consts.vh"

// Overview of operation
// - Each request leaves as a two-cycle address packet on the 29-bit address bus.
// - Address-valid strobe is high only in the first packet cycle.
// - Between packets the address bus carries internal debug state.
// - Host reply code announces write data or orders slave to drive read data.
// - Differential slave clock runs at one third of the core clock.
// - Slave reset asserts asynchronously and releases monotonically.
module spar_host_port #(
    parameter [2:0] HREPLY_IDLE  = `SPAR_HREPLY_IDLE,
    parameter [2:0] HREPLY_WDATA = `SPAR_HREPLY_WDATA,
    parameter [2:0] HREPLY_RDATA = `SPAR_HREPLY_RDATA,
    parameter [1:0] SREPLY_WDONE = `SPAR_SREPLY_WDONE,
    parameter [1:0] SREPLY_RDRDY = `SPAR_SREPLY_RDRDY
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        req_valid,
    output wire        req_ready,
    input  wire        req_write,
    input  wire [28:0] req_addr_first,
    input  wire [28:0] req_addr_second,
    input  wire [63:0] req_wdata,
    output wire [63:0] rsp_rdata,
    output wire        rsp_valid,
    output wire        wr_done,
    output wire        busy,
    output wire [28:0] system_address_bus,
    output wire        address_valid_strobe,
    output wire [2:0]  host_reply,
    input  wire [1:0]  slave_reply,
    input  wire [63:0] shared_data_bus_in,
    output wire [63:0] shared_data_bus_out,
    output wire        shared_data_bus_oe_n,
    output wire        slave_clock_true,
    output wire        slave_clock_comp,
    output wire        slave_reset_n
);

    // ============================================================
    // States
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADR1  = 3'h1;
    localparam [2:0] ST_ADR2  = 3'h2;
    localparam [2:0] ST_WDAT  = 3'h3;
    localparam [2:0] ST_WWAIT = 3'h4;
    localparam [2:0] ST_RWAIT = 3'h5;
    localparam [2:0] ST_RCMD  = 3'h6;
    localparam [2:0] ST_RCAP  = 3'h7;

    wire        tick;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [28:0] adr_bus_reg;
    reg  [28:0] adr_bus_next;
    reg         strobe_reg;
    reg         strobe_next;
    reg  [2:0]  hreply_reg;
    reg  [2:0]  hreply_next;
    reg  [63:0] dout_reg;
    reg  [63:0] dout_next;
    reg         oe_n_reg;
    reg         oe_n_next;
    reg  [28:0] second_reg;
    reg  [28:0] second_next;
    reg         write_reg;
    reg         write_next;
    reg  [63:0] rdata_reg;
    reg  [63:0] rdata_next;
    reg         rsp_valid_reg;
    reg         rsp_valid_next;
    reg         wr_done_reg;
    reg         wr_done_next;
    reg  [15:0] txn_cnt_reg;
    reg  [15:0] txn_cnt_next;
    reg  [1:0]  sreply_meta_reg;
    reg  [1:0]  sreply_sync_reg;
    reg  [63:0] din_meta_reg;
    reg  [63:0] din_sync_reg;
    reg         rst_meta_reg;
    reg         rst_sync_reg;
    wire        take;

    // ============================================================
    // Debug word shown on the idle address bus
    function [28:0] debug_word;
        input [2:0]  st;
        input        wr;
        input [15:0] cnt;
        begin
            debug_word = {9'h000, wr, st, cnt};
        end
    endfunction

    // ============================================================
    // Slave clock generation
    spar_clk_div #(
        .DIV   (`SPAR_CLK_DIV),
        .PHASE (`SPAR_TICK_PHASE)
    ) u_clk_div (
        .clk      (clk),
        .nrst     (nrst),
        .tick     (tick),
        .clk_true (slave_clock_true),
        .clk_comp (slave_clock_comp)
    );

    // ============================================================
    // Slave reset release
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ============================================================
    // Pin input synchronisers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sreply_meta_reg <= 2'h0;
            sreply_sync_reg <= 2'h0;
            din_meta_reg    <= `SPAR_DATA_RST;
            din_sync_reg    <= `SPAR_DATA_RST;
        end else begin
            sreply_meta_reg <= slave_reply;
            sreply_sync_reg <= sreply_meta_reg;
            din_meta_reg    <= shared_data_bus_in;
            din_sync_reg    <= din_meta_reg;
        end
    end

    assign take = req_valid && req_ready;

    // ============================================================
    // Transfer sequencer, advancing once per slave clock
    always @* begin
        state_next     = state_reg;
        adr_bus_next   = adr_bus_reg;
        strobe_next    = strobe_reg;
        hreply_next    = hreply_reg;
        dout_next      = dout_reg;
        oe_n_next      = oe_n_reg;
        second_next    = second_reg;
        write_next     = write_reg;
        rdata_next     = rdata_reg;
        txn_cnt_next   = txn_cnt_reg;
        rsp_valid_next = 1'b0;
        wr_done_next   = 1'b0;
        if (tick) begin
            case (state_reg)
                ST_IDLE: begin
                    adr_bus_next = debug_word(state_reg, write_reg, txn_cnt_reg);
                    if (take) begin
                        state_next   = ST_ADR1;
                        adr_bus_next = req_addr_first;
                        strobe_next  = 1'b1;
                        second_next  = req_addr_second;
                        write_next   = req_write;
                        dout_next    = req_wdata;
                    end
                end
                ST_ADR1: begin
                    state_next   = ST_ADR2;
                    adr_bus_next = second_reg;
                    strobe_next  = 1'b0;
                end
                ST_ADR2: begin
                    adr_bus_next = debug_word(state_reg, write_reg, txn_cnt_reg);
                    if (write_reg) begin
                        state_next  = ST_WDAT;
                        hreply_next = HREPLY_WDATA;
                        oe_n_next   = 1'b0;
                    end else begin
                        state_next  = ST_RWAIT;
                    end
                end
                ST_WDAT: begin
                    state_next  = ST_WWAIT;
                    hreply_next = HREPLY_IDLE;
                    oe_n_next   = 1'b1;
                end
                ST_WWAIT: begin
                    adr_bus_next = debug_word(state_reg, write_reg, txn_cnt_reg);
                    if (sreply_sync_reg == SREPLY_WDONE) begin
                        state_next   = ST_IDLE;
                        wr_done_next = 1'b1;
                        txn_cnt_next = txn_cnt_reg + 16'h0001;
                    end
                end
                ST_RWAIT: begin
                    adr_bus_next = debug_word(state_reg, write_reg, txn_cnt_reg);
                    if (sreply_sync_reg == SREPLY_RDRDY) begin
                        state_next  = ST_RCMD;
                        hreply_next = HREPLY_RDATA;
                    end
                end
                ST_RCMD: begin
                    state_next  = ST_RCAP;
                    hreply_next = HREPLY_IDLE;
                end
                ST_RCAP: begin
                    state_next     = ST_IDLE;
                    rdata_next     = din_sync_reg;
                    rsp_valid_next = 1'b1;
                    txn_cnt_next   = txn_cnt_reg + 16'h0001;
                end
                default: begin
                    state_next  = ST_IDLE;
                    strobe_next = 1'b0;
                    hreply_next = HREPLY_IDLE;
                    oe_n_next   = 1'b1;
                end
            endcase
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= ST_IDLE;
            adr_bus_reg   <= `SPAR_ADDR_RST;
            strobe_reg    <= 1'b0;
            hreply_reg    <= HREPLY_IDLE;
            dout_reg      <= `SPAR_DATA_RST;
            oe_n_reg      <= 1'b1;
            second_reg    <= `SPAR_ADDR_RST;
            write_reg     <= 1'b0;
            rdata_reg     <= `SPAR_DATA_RST;
            rsp_valid_reg <= 1'b0;
            wr_done_reg   <= 1'b0;
            txn_cnt_reg   <= 16'h0000;
        end else begin
            state_reg     <= state_next;
            adr_bus_reg   <= adr_bus_next;
            strobe_reg    <= strobe_next;
            hreply_reg    <= hreply_next;
            dout_reg      <= dout_next;
            oe_n_reg      <= oe_n_next;
            second_reg    <= second_next;
            write_reg     <= write_next;
            rdata_reg     <= rdata_next;
            rsp_valid_reg <= rsp_valid_next;
            wr_done_reg   <= wr_done_next;
            txn_cnt_reg   <= txn_cnt_next;
        end
    end

    // ============================================================
    // Outputs
    assign req_ready            = (state_reg == ST_IDLE) && tick;
    assign busy                 = (state_reg != ST_IDLE);
    assign rsp_rdata            = rdata_reg;
    assign rsp_valid            = rsp_valid_reg;
    assign wr_done              = wr_done_reg;
    assign system_address_bus   = adr_bus_reg;
    assign address_valid_strobe = strobe_reg;
    assign host_reply           = hreply_reg;
    assign shared_data_bus_out  = dout_reg;
    assign shared_data_bus_oe_n = oe_n_reg;
    assign slave_reset_n        = rst_sync_reg;

endmodule

// >>> spar_host_port_tb.sv
`include "spar_consts.vh"
`define SPAR_CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module spar_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk, nrst, req_valid, req_write;
    reg [28:0] req_addr_first, req_addr_second;
    reg [63:0] req_wdata, m_rd;
    reg [3:0] m_delay;
    reg [31:0] cyc = 32'h0;
    integer fail_count, samples_checked, txn, k;
    wire req_ready, rsp_valid, wr_done, busy, strobe, oe_n, sck_t, sck_c, srst_n, m_drive, m_bad;
    wire [63:0] rsp_rdata, dout, bus, m_data, m_wdata;
    wire [28:0] sab, m_first, m_second;
    wire [2:0] hrep;
    wire [1:0] srep;
    // Undriven bus shows a changing pattern, not the last value
    assign bus = !oe_n ? dout : m_drive ? m_data : {~cyc, cyc};
    spar_host_port spar_host_port_i (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr_first(req_addr_first), .req_addr_second(req_addr_second),
        .req_wdata(req_wdata), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .wr_done(wr_done), .busy(busy),
        .system_address_bus(sab), .address_valid_strobe(strobe), .host_reply(hrep), .slave_reply(srep),
        .shared_data_bus_in(bus), .shared_data_bus_out(dout), .shared_data_bus_oe_n(oe_n),
        .slave_clock_true(sck_t), .slave_clock_comp(sck_c), .slave_reset_n(srst_n));
    spar_slave_model spar_slave_model_i (.sclk(sck_t), .srst_n(srst_n), .addr_bus(sab), .strobe(strobe),
        .hrep(hrep), .data_bus(bus), .delay(m_delay), .rd_word(m_rd), .srep(srep), .drive(m_drive),
        .drive_data(m_data), .got_first(m_first), .got_second(m_second), .got_wdata(m_wdata), .strobe_bad(m_bad));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 32'h1;
    task end_sim;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic req(input w, input [28:0] a, input [28:0] b, input [63:0] d);
        integer n;
        @(posedge clk);
        req_valid <= 1'b1; req_write <= w; req_addr_first <= a; req_addr_second <= b; req_wdata <= d;
        n = 0;
        do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 20);
        if (req_ready !== 1'b1) begin fail_count++; $display("BAD %0t request never taken", $time); end_sim(); end
        @(posedge clk);
        req_valid <= 1'b0;
        do begin @(negedge clk); n++; end while ((w ? wr_done : rsp_valid) !== 1'b1 && n < 400);
        if (n >= 400) begin fail_count++; $display("BAD %0t no completion", $time); end_sim(); end
        txn++;
    endtask
    task automatic t_write(input [3:0] dl, input [28:0] a, input [28:0] b, input [63:0] d);
        m_delay = dl;
        req(1'b1, a, b, d);
        `SPAR_CHECK(m_first, a)
        `SPAR_CHECK(m_second, b)
        `SPAR_CHECK(m_bad, 1'b0)
        `SPAR_CHECK(m_wdata, d)
        $display("write test done");
    endtask
    task automatic t_read(input [3:0] dl, input [28:0] a, input [63:0] d);
        m_delay = dl;
        m_rd = d;
        req(1'b0, a, ~a, 64'h0);
        `SPAR_CHECK(m_first, a)
        `SPAR_CHECK(m_second, ~a)
        `SPAR_CHECK(m_bad, 1'b0)
        `SPAR_CHECK(rsp_rdata, d)
        $display("read test done");
    endtask
    task automatic t_idle;
        integer r;
        reg     prev;
        r = 0;
        prev = sck_t;
        repeat (30) begin
            @(negedge clk);
            if (sck_t === 1'b1 && prev === 1'b0) r++;
            prev = sck_t;
            `SPAR_CHECK(sck_c, ~sck_t)
        end
        `SPAR_CHECK(r, 10)
        `SPAR_CHECK(busy, 1'b0)
        `SPAR_CHECK(sab[15:0], txn[15:0])
        $display("clock test done");
    endtask
    task automatic t_midreset;
        @(posedge clk);
        nrst <= 1'b0;
        #1 `SPAR_CHECK(srst_n, 1'b0)
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        txn = 0;
        @(negedge clk) `SPAR_CHECK(srst_n, 1'b0)
        repeat (3) @(negedge clk);
        `SPAR_CHECK(srst_n, 1'b1)
        $display("reset test done");
    endtask
    initial begin
        nrst = 1'b0; req_valid = 1'b0; req_write = 1'b0; req_addr_first = 29'h0; req_addr_second = 29'h0;
        req_wdata = 64'h0; m_rd = 64'h0; m_delay = 4'h0; fail_count = 0; samples_checked = 0; txn = 0;
        repeat (10) @(posedge clk);
        `SPAR_CHECK(srst_n, 1'b0)
        `SPAR_CHECK(oe_n, 1'b1)
        nrst <= 1'b1;
        t_write(4'h0, 29'h1FFFFFFF, 29'h00000001, 64'hFEDCBA9876543210);
        t_write(4'h9, 29'h0AAAAAAA, 29'h15555555, 64'h0123456789ABCDEF);
        t_read(4'h0, 29'h00C0FFEE, 64'hA5A5A5A55A5A5A5A);
        t_read(4'h7, 29'h10000000, 64'hFFFFFFFF00000000);
        t_write(4'h2, 29'h00000000, 29'h1FFFFFFF, 64'h8000000000000001);
        t_idle();
        t_midreset();
        t_read(4'h1, 29'h12345678, 64'h0F0F0F0F0F0F0F0F);
        t_idle();
        end_sim();
    end
endmodule

// >>> spar_slave_model.sv
`include "spar_consts.vh"
// ====================
// Behavioural slave on the link
module spar_slave_model (
    input  wire        sclk,
    input  wire        srst_n,
    input  wire [28:0] addr_bus,
    input  wire        strobe,
    input  wire [2:0]  hrep,
    input  wire [63:0] data_bus,
    input  wire [3:0]  delay,
    input  wire [63:0] rd_word,
    output reg  [1:0]  srep,
    output reg         drive,
    output reg  [63:0] drive_data,
    output reg  [28:0] got_first,
    output reg  [28:0] got_second,
    output reg  [63:0] got_wdata,
    output reg         strobe_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [2:0] phase;
    reg [3:0] cnt;
    always @(posedge sclk or negedge srst_n) begin
        if (!srst_n) begin
            phase <= 3'h0; cnt <= 4'h0; srep <= `SPAR_SREPLY_IDLE; drive <= 1'b0;
            drive_data <= 64'h0; got_first <= 29'h0; got_second <= 29'h0; got_wdata <= 64'h0;
            strobe_bad <= 1'b0;
        end else begin
            case (phase)
                3'h0: if (strobe) begin got_first <= addr_bus; phase <= 3'h1; end
                3'h1: begin got_second <= addr_bus; strobe_bad <= strobe; phase <= 3'h2; end
                3'h2: begin
                    cnt <= delay;
                    if (hrep == `SPAR_HREPLY_WDATA) begin got_wdata <= data_bus; phase <= 3'h3; end
                    else phase <= 3'h5;
                end
                3'h3: if (cnt == 4'h0) begin srep <= `SPAR_SREPLY_WDONE; cnt <= 4'h1; phase <= 3'h4; end
                    else cnt <= cnt - 4'h1;
                3'h4: if (cnt == 4'h0) begin srep <= `SPAR_SREPLY_IDLE; phase <= 3'h0; end
                    else cnt <= cnt - 4'h1;
                3'h5: if (cnt == 4'h0) begin srep <= `SPAR_SREPLY_RDRDY; phase <= 3'h6; end
                    else cnt <= cnt - 4'h1;
                3'h6: if (hrep == `SPAR_HREPLY_RDATA) begin
                    srep <= `SPAR_SREPLY_IDLE; drive <= 1'b1; drive_data <= rd_word; cnt <= 4'h1; phase <= 3'h7;
                end
                default: if (cnt == 4'h0) begin drive <= 1'b0; phase <= 3'h0; end
                    else cnt <= cnt - 4'h1;
            endcase
        end
    end
endmodule
